// ### modem_lines_top.sv
`timescale 1ns/1ps
`default_nettype none
module modem_lines_top #(
  parameter bit STRAP_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [modem_lines_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [modem_lines_pkg::DATA_W-1:0] pwdata,
  output logic [modem_lines_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [modem_lines_pkg::NUM_CHAN-1:0] ring_indicator_inputs_n,
  input wire logic crystal_strap_pin,
  output logic [modem_lines_pkg::NUM_CHAN-1:0] request_to_send_outputs_n,
  output logic [modem_lines_pkg::NUM_CHAN-1:0] modem_status_irq,
  output logic [modem_lines_pkg::NUM_CHAN-1:0] loop_mode
);
  import modem_lines_pkg::*;

  logic [NUM_CHAN-1:0] modem_ctrl_rts_bit;
  logic [NUM_CHAN-1:0] loop_bit;
  logic [NUM_CHAN-1:0] int_enable;
  logic crystal_select_strap;
  logic strap_sync;
  logic strap_pending;
  logic [NUM_CHAN-1:0] ring_active;
  logic [NUM_CHAN-1:0] trailing_flag;
  logic [NUM_CHAN-1:0] chan_irq;
  logic [NUM_CHAN-1:0] read_clear;

  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready;
  wire wr_done = access_done & pwrite;
  wire rd_done = access_done & ~pwrite;

  wire hit_ctrl0 = (paddr == CH0_CTRL_OFFSET);
  wire hit_stat0 = (paddr == CH0_STATUS_OFFSET);
  wire hit_ctrl1 = (paddr == CH1_CTRL_OFFSET);
  wire hit_stat1 = (paddr == CH1_STATUS_OFFSET);
  wire hit_inten = (paddr == INT_ENABLE_OFFSET);
  wire hit_state = (paddr == BLOCK_STATE_OFFSET);
  wire [NUM_CHAN-1:0] hit_ctrl = {hit_ctrl1, hit_ctrl0};
  wire [NUM_CHAN-1:0] hit_stat = {hit_stat1, hit_stat0};
  wire mapped = |{hit_ctrl, hit_stat, hit_inten, hit_state};

  // without the strap variant loop mode always pins rts inactive
  wire loop_holds_rts = STRAP_VARIANT ? crystal_select_strap : 1'b1;

  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] ctrl_word [NUM_CHAN];
  logic [DATA_W-1:0] stat_word [NUM_CHAN];
  logic [DATA_W-1:0] state_word;

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      ctrl_word[i] = '0;
      ctrl_word[i][CTRL_RTS_BIT] = modem_ctrl_rts_bit[i];
      ctrl_word[i][CTRL_LOOP_BIT] = loop_bit[i];
      stat_word[i] = '0;
      stat_word[i][STAT_RING_BIT] = ring_active[i];
      stat_word[i][STAT_TRAILING_RING_BIT] = trailing_flag[i];
    end
    state_word = '0;
    state_word[STATE_STRAP_BIT] = crystal_select_strap;
    state_word[STATE_IRQ_LSB +: NUM_CHAN] = chan_irq;
  end

  assign next_rdata = hit_ctrl0 ? ctrl_word[0] :
                      hit_stat0 ? stat_word[0] :
                      hit_ctrl1 ? ctrl_word[1] :
                      hit_stat1 ? stat_word[1] :
                      hit_inten ? {{(DATA_W-NUM_CHAN){1'b0}}, int_enable} :
                      hit_state ? state_word : '0;

  // answer is ready in the first access cycle; data is captured at setup
  assign pready = 1'b1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? '0 : next_rdata;
      pslverr <= ~mapped;
    end
  end

  // clear only a flag that this read actually reported, so an edge landing
  // between setup and access is kept for the next read
  assign read_clear = {NUM_CHAN{rd_done}} & hit_stat &
                      {NUM_CHAN{prdata[STAT_TRAILING_RING_BIT]}};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modem_ctrl_rts_bit <= {NUM_CHAN{CTRL_RTS_RESET}};
      loop_bit <= {NUM_CHAN{CTRL_LOOP_RESET}};
      int_enable <= INT_ENABLE_RESET;
    end else if (wr_done) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (hit_ctrl[i]) begin
          modem_ctrl_rts_bit[i] <= pwdata[CTRL_RTS_BIT];
          loop_bit[i] <= pwdata[CTRL_LOOP_BIT];
        end
      end
      if (hit_inten) begin
        int_enable <= pwdata[NUM_CHAN-1:0];
      end
    end
  end

  pin_sync #(.WIDTH(1)) strap_sync_i (
    .sys_clk(sys_clk),
    .pin(crystal_strap_pin),
    .synced(strap_sync)
  );

  // strap is caught once, in the first cycle after reset is released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_pending <= 1'b1;
      crystal_select_strap <= STRAP_RESET;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      crystal_select_strap <= strap_sync;
    end
  end

  assign loop_mode = loop_bit;
  assign modem_status_irq = chan_irq;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    modem_chan_if link ();

    assign link.rts_bit = modem_ctrl_rts_bit[c];
    assign link.loop_on = loop_bit[c];
    assign link.int_enable = int_enable[c];
    assign link.loop_holds_rts = loop_holds_rts;
    assign link.trailing_ring_clear = read_clear[c];
    assign ring_active[c] = link.ring_active;
    assign trailing_flag[c] = link.ring_trailing_edge_flag;
    assign chan_irq[c] = link.irq;

    modem_channel chan_i (
      .sys_clk(sys_clk),
      .rst(rst),
      .ring_indicator_n(ring_indicator_inputs_n[c]),
      .request_to_send_n(request_to_send_outputs_n[c]),
      .link(link.chan)
    );
  end
endmodule
`default_nettype wire

// ### modem_lines_pkg.sv
package modem_lines_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CHAN = 2;

  localparam logic [ADDR_W-1:0] CH0_CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CH0_STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] CH1_CTRL_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] CH1_STATUS_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] INT_ENABLE_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] BLOCK_STATE_OFFSET = 8'h14;

  // modem control register fields
  localparam int CTRL_RTS_BIT = 1;
  localparam int CTRL_LOOP_BIT = 4;
  // modem status register fields
  localparam int STAT_TRAILING_RING_BIT = 2;
  localparam int STAT_RING_BIT = 6;
  // block state register fields
  localparam int STATE_STRAP_BIT = 0;
  localparam int STATE_IRQ_LSB = 1;

  localparam logic CTRL_RTS_RESET = 1'b0;
  localparam logic CTRL_LOOP_RESET = 1'b0;
  localparam logic [NUM_CHAN-1:0] INT_ENABLE_RESET = 2'h0;
  localparam logic RTS_PIN_RESET_N = 1'b1;
  localparam logic STRAP_RESET = 1'b0;

  localparam int SYNC_STAGES = 2;
endpackage

// ### modem_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface modem_chan_if;
  logic rts_bit;
  logic loop_on;
  logic int_enable;
  logic loop_holds_rts;
  logic trailing_ring_clear;
  logic ring_active;
  logic ring_trailing_edge_flag;
  logic irq;

  modport ctrl (
    output rts_bit,
    output loop_on,
    output int_enable,
    output loop_holds_rts,
    output trailing_ring_clear,
    input ring_active,
    input ring_trailing_edge_flag,
    input irq
  );

  modport chan (
    input rts_bit,
    input loop_on,
    input int_enable,
    input loop_holds_rts,
    input trailing_ring_clear,
    output ring_active,
    output ring_trailing_edge_flag,
    output irq
  );
endinterface
`default_nettype wire

// ### pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] synced
);
  // first stage feeds only the second; no reset so the pin level is live
  // through reset and valid at release
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk) begin
    stage1 <= pin;
    synced <= stage1;
  end
endmodule
`default_nettype wire

// ### modem_channel.sv
`timescale 1ns/1ps
`default_nettype none
module modem_channel (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ring_indicator_n,
  output logic request_to_send_n,
  modem_chan_if.chan link
);
  import modem_lines_pkg::*;

  logic ring_n_sync;
  logic ring_n_prev;
  wire ring_released;
  wire next_rts_n;

  pin_sync #(.WIDTH(1)) ring_sync (
    .sys_clk(sys_clk),
    .pin(ring_indicator_n),
    .synced(ring_n_sync)
  );

  assign ring_released = ~ring_n_prev & ring_n_sync;
  assign link.ring_active = ~ring_n_sync;

  // loop mode may pin the output high, otherwise it follows the rts bit
  assign next_rts_n = (link.loop_on && link.loop_holds_rts) ?
                      RTS_PIN_RESET_N : ~link.rts_bit;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ring_n_prev <= 1'b1;
    end else begin
      ring_n_prev <= ring_n_sync;
    end
  end

  // a new edge in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.ring_trailing_edge_flag <= 1'b0;
    end else if (ring_released) begin
      link.ring_trailing_edge_flag <= 1'b1;
    end else if (link.trailing_ring_clear) begin
      link.ring_trailing_edge_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.irq <= 1'b0;
      request_to_send_n <= RTS_PIN_RESET_N;
    end else begin
      link.irq <= link.ring_trailing_edge_flag & link.int_enable;
      request_to_send_n <= next_rts_n;
    end
  end
endmodule
`default_nettype wire

// ### modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  input wire logic sys_clk,
  input wire logic [1:0] ring_cmd,
  input wire logic [1:0] rts_n,
  output logic [1:0] ring_n = 2'h3
);
  // line idles high; a ring pulls it low, one edge after the request
  always_ff @(posedge sys_clk) begin
    ring_n <= ring_cmd;
  end
endmodule
`default_nettype wire

// ### modem_lines_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module modem_lines_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [1:0] ring_indicator_inputs_n,
  input wire logic crystal_strap_pin,
  input wire logic [1:0] request_to_send_outputs_n,
  input wire logic [1:0] modem_status_irq
);
  logic [3:0] h0;
  logic strap;
  logic [1:0] en;
  wire acc = psel && penable;
  wire wr0 = acc && pwrite && paddr == 8'h00;
  wire rd0 = acc && !pwrite && paddr == 8'h04;
  wire st0 = psel && !penable && !pwrite && paddr == 8'h04;
  wire [1:0] ri = ring_indicator_inputs_n;
  wire [1:0] rts = request_to_send_outputs_n;
  wire [1:0] irq = modem_status_irq;
  // strap pin is held steady across reset, so its level is the captured one
  always_ff @(posedge sys_clk) begin
    h0 <= {h0[2:0], ri[0]};
    if (rst) strap <= crystal_strap_pin;
    if (rst) en <= 2'h0;
    else if (acc && pwrite && paddr == 8'h10) en <= pwdata[1:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rts_reset: assert property ($fell(rst) |-> &rts)
    else $error("rts not idle after reset");
  a_irq_reset: assert property ($fell(rst) |-> irq == 2'h0)
    else $error("irq set after reset");
  // register loads at the access edge, the pin one edge later
  a_rts_ctrl: assert property (wr0 && !(pwdata[4] && strap)
    |-> ##2 rts[0] == !$past(pwdata[1], 2)) else $error("rts wrong");
  a_loop_hold: assert property (wr0 && pwdata[4] && strap |-> ##2 rts[0])
    else $error("rts not held in loop");
  a_ring_status: assert property (st0 && (h0 == 4'hf || h0 == 4'h0)
    |=> prdata[6] == !h0[1]) else $error("ring status wrong");
  a_irq_rise: assert property (en[0] && $rose(ri[0]) |-> ##4 irq[0])
    else $error("no irq after ring end");
  a_irq_masked: assert property (!en[0] |=> !irq[0])
    else $error("masked irq raised");
  a_flag_clear: assert property (rd0 && prdata[2] && &{h0, ri[0]}
    |-> ##2 !irq[0]) else $error("flag not cleared");
  a_bad_addr: assert property (psel && !penable && paddr > 8'h14
    |=> pslverr && prdata == 32'h0) else $error("unmapped access");
endmodule
bind modem_lines_top modem_lines_monitor modem_lines_monitor_inst (
  .sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pslverr, .ring_indicator_inputs_n, .crystal_strap_pin,
  .request_to_send_outputs_n, .modem_status_irq);
`default_nettype wire

// ### modem_lines_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module modem_lines_top_tb;
  import modem_lines_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic strap = 1, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr;
  logic [1:0] ring_n, ring_cmd = 2'h3, rts_n, irq, loop, en;
  int failures = 0, n_compared = 0, bit_r;
  initial forever #5 sys_clk = ~sys_clk;
  modem_lines_top modem_lines_top_inst (.sys_clk, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ring_indicator_inputs_n(ring_n), .crystal_strap_pin(strap),
    .request_to_send_outputs_n(rts_n), .modem_status_irq(irq),
    .loop_mode(loop));
  modem_model modem_model_inst (.sys_clk, .ring_cmd, .rts_n, .ring_n);
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge sys_clk);
  endtask
  task rd_stat(input logic [31:0] e);
    for (int ch = 0; ch < 2; ch++) begin
      apb(8'(8 * ch + 4), 1'b0, 32'h0);
      chk(r, e);
    end
  endtask
  initial begin
    bit_r = $urandom(54);
    for (int s = 1; s >= 0; s--) begin
      // pins change only just after a rising edge, also for the mid-run reset
      @(posedge sys_clk);
      strap <= s[0];
      rst <= 1;
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      @(negedge sys_clk);
      chk(rts_n, 2'h3);
      chk(irq, 2'h0);
      apb(BLOCK_STATE_OFFSET, 1'b0, 32'h0);
      chk(r[0], s[0]);
      for (int ch = 0; ch < 2; ch++) begin
        bit_r = $urandom % 2;
        apb(8'(8 * ch), 1'b1, 32'(bit_r << 1));
        // rts pin is registered from the control bit, one edge after the write
        @(negedge sys_clk);
        chk(rts_n[ch], !bit_r);
        apb(8'(8 * ch), 1'b1, 32'h12);
        @(negedge sys_clk);
        chk(rts_n[ch], s[0]);
        chk(loop[ch], 1'b1);
        apb(8'(8 * ch), 1'b1, 32'h0);
      end
      $display("rts and loop test done, strap %0d", s);
    end
    // one channel enabled, the other masked, chosen at random
    en = 2'h1 << ($urandom % 2);
    apb(INT_ENABLE_OFFSET, 1'b1, 32'(en));
    @(posedge sys_clk) ring_cmd <= 2'h0;
    repeat (8) @(posedge sys_clk);
    rd_stat(32'h40);
    @(posedge sys_clk) ring_cmd <= 2'h3;
    repeat (8) @(negedge sys_clk);
    chk(irq, en);
    rd_stat(32'h4);
    repeat (2) @(negedge sys_clk);
    chk(irq, 2'h0);
    rd_stat(32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk(r, 32'h0);
    chk(err, 1'b1);
    $display("ring and map test done");
    wrap_up;
  end
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
